/* File: bench/acr_host_model.sv */
/* Host side of the control bus front end: hands over whole register words.
   Assumes the register block's clock; idle lines show the inverse word. */
`default_nettype none
module acr_host_model (
    // Clock
    input wire logic clk,
    // Word write
    output var logic wrStrobe,
    output var logic [6:0] wrAddr,
    output var logic [15:0] wrData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wrStrobe = 1'b0;
        wrAddr = 7'h7f;
        wrData = 16'h0000;
    end
    task automatic write_word(input logic [6:0] addr, input logic [15:0] data, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        wrStrobe <= 1'b1;
        wrAddr <= addr;
        if (addr == 7'h00 && data[5:2] > 4'h8) data[5:2] = 4'h8;
        wrData <= data;
        @(posedge clk);
        wrStrobe <= 1'b0;
        wrAddr <= ~addr;
        wrData <= ~data;
    endtask : write_word
endmodule : acr_host_model
`default_nettype wire

/* File: bench/testbench.sv */
/* Self-checking bench for the setup and record gain registers.
   Assumes acr_pkg and a short soft-step period for simulation. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import acr_pkg::*;
    localparam int STEP = 4;
    logic clk = 1'b0, rstn = 1'b0;
    logic [6:0] rdAddr = 7'h00, lastCode = 7'h00;
    wire logic wrStrobe, dcBlockBypass, sourceIsMix, sampleRateValid, wordIs20Bit;
    wire logic playbackLeftJustified, standardFraming, recordMute, recordGainBusy;
    wire logic [6:0] wrAddr, recordGainApplied;
    wire logic [15:0] wrData, rdData;
    wire logic [1:0] dcBlockCornerSel, recordSourceSel, preampGainDb6, serialWordFormat;
    wire logic [9:0] mclkRatio;
    wire logic [3:0] sampleRateSel;
    int errTotal = 0, comparisons = 0, cyc = 0, sinceStep = 0, setupM;
    logic [15:0] w;
    always #5 clk = ~clk;
    acr_host_model host (.clk(clk), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData));
    acr_regs #(.STEP_CYC(STEP)) uut (.clk(clk), .rstn(rstn), .wrStrobe(wrStrobe), .wrAddr(wrAddr),
        .wrData(wrData), .rdAddr(rdAddr), .rdData(rdData), .dcBlockCornerSel(dcBlockCornerSel),
        .dcBlockBypass(dcBlockBypass), .recordSourceSel(recordSourceSel), .sourceIsMix(sourceIsMix),
        .preampGainDb6(preampGainDb6), .mclkRatio(mclkRatio), .sampleRateSel(sampleRateSel),
        .sampleRateValid(sampleRateValid), .serialWordFormat(serialWordFormat),
        .wordIs20Bit(wordIs20Bit), .playbackLeftJustified(playbackLeftJustified),
        .standardFraming(standardFraming), .recordGainApplied(recordGainApplied),
        .recordMute(recordMute), .recordGainBusy(recordGainBusy));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errTotal++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic read_check(input logic [6:0] a, input int exp);
        @(posedge clk);
        rdAddr <= a;
        @(negedge clk);
        check(rdData, 16'(exp));
    endtask : read_check
    task automatic check_decode();
        int c, s, p, m, f;
        c = (setupM >> 14) & 3;
        s = (setupM >> 12) & 3;
        p = (setupM >> 8) & 3;
        m = (setupM >> 6) & 3;
        f = setupM & 3;
        check(16'({dcBlockCornerSel, dcBlockBypass}), 16'(c * 2 + (c == 0)));
        check(16'({recordSourceSel, sourceIsMix}), 16'(s * 2 + (s == 3)));
        check(16'(preampGainDb6), 16'(p < 2 ? 0 : p - 1));
        check(16'(mclkRatio), 16'(m == 1 ? 384 : (m == 2 ? 512 : 256)));
        check(16'({sampleRateSel, sampleRateValid}), 16'((((setupM >> 2) & 15) * 2) + (((setupM >> 2) & 15) <= 8)));
        check(16'({wordIs20Bit, playbackLeftJustified, standardFraming, serialWordFormat}),
            16'((f != 0) * 16 + (f == 2) * 8 + (f == 3) * 4 + f));
    endtask : check_decode
    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        setupM = 'hc003;
        read_check(7'h00, 'hc003);
        read_check(7'h01, 'hd700);
        check(16'({recordMute, recordGainApplied}), 16'h0087);
        check_decode();
    endtask : do_reset
    task automatic gain_case(input logic [15:0] v, input int expCode, input int expMute);
        int n;
        host.write_word(7'h01, v, 0);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(16'(recordGainBusy), 16'h1);
        for (n = 0; n < 1000 && recordGainBusy !== 1'b0; n++) @(negedge clk);
        check(16'(n < 1000), 16'h1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(16'(recordGainApplied), 16'(expCode));
        check(16'(recordMute), 16'(expMute));
        read_check(7'h01, v & 16'hff00);
    endtask : gain_case
    always @(negedge clk) begin
        if (rstn && recordGainApplied != lastCode) begin
            check(16'(recordGainApplied - lastCode == 7'h01 || lastCode - recordGainApplied == 7'h01), 16'h1);
            check(16'(sinceStep >= STEP - 1), 16'h1);
            sinceStep = 0;
        end else sinceStep++;
        lastCode = recordGainApplied;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errTotal++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'he6fd6133));
        do_reset();
        for (int i = 0; i < 36; i++) begin
            w = 16'($urandom);
            w[15:14] = 2'(i % 4);
            w[13:12] = 2'(i / 4);
            w[9:8] = 2'(i / 3);
            w[7:6] = 2'(i / 2);
            w[5:2] = 4'(i % 9);
            w[1:0] = 2'(i / 5);
            host.write_word(7'h00, w, i % 3);
            setupM = w & 16'hf3ff;
            read_check(7'h00, setupM);
            check_decode();
        end
        host.write_word(7'h02, 16'($urandom), 0);
        read_check(7'h02, 0);
        read_check(7'h00, setupM);
        gain_case(16'h5700 | 16'($urandom % 256), 'h57, 0);
        gain_case(16'hd7a5, 'h07, 1);
        gain_case(16'h7f00, 'h7f, 0);
        gain_case(16'h0300, 'h07, 1);
        gain_case(16'h5a3c, 'h5a, 0);
        do_reset();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire

/* File: core/acr_gain_ramp.sv */
/*
 * Soft-stepping record gain: walks the applied gain one code per step period
 * toward the target, down to the floor and then mute when muting.
 * Assumes the target and mute inputs are held stable by the register file.
 */
`default_nettype none
module acr_gain_ramp #(
    parameter int STEP_CYC = acr_pkg::STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic muteReq,
    input wire logic [6:0] targetCode,
    // Applied gain
    output logic [6:0] appliedCode,
    output logic recordMuted,
    output logic rampBusy
);
    import acr_pkg::*;

    logic [6:0] gain_reg;
    logic [6:0] gain_next;
    logic [15:0] tick_reg;
    logic muted_reg;
    logic muted_next;
    acr_ramp_t state_reg;
    acr_ramp_t state_next;

    wire tickDone = (tick_reg == 16'(STEP_CYC - 1));
    wire targetMutes = (targetCode < GAIN_MIN);
    // Goal is the floor when muting, else the programmed code
    wire [6:0] goal = (muteReq || targetMutes) ? GAIN_MIN : targetCode;
    wire atGoal = (gain_reg == goal);
    wire wantMute = muteReq || targetMutes;

    always_comb begin
        gain_next = gain_reg;
        muted_next = muted_reg;
        state_next = state_reg;
        case (state_reg)
            ACR_MUTED: begin
                if (!wantMute) begin
                    muted_next = 1'b0;
                    state_next = ACR_RAMP;
                end
            end
            ACR_RAMP, ACR_ACTIVE: begin
                if (atGoal) begin
                    if (wantMute) begin
                        muted_next = 1'b1;
                        state_next = ACR_MUTED;
                    end else begin
                        state_next = ACR_ACTIVE;
                    end
                end else begin
                    // Busy as soon as the goal moves, not only at the next tick
                    state_next = ACR_RAMP;
                    if (tickDone) begin
                        gain_next = (gain_reg < goal) ? gain_reg + 7'h01 : gain_reg - 7'h01;
                    end
                end
            end
            default: state_next = ACR_MUTED;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            gain_reg <= GAIN_MIN;
            muted_reg <= 1'b1;
            state_reg <= ACR_MUTED;
            tick_reg <= 16'h0000;
        end else begin
            gain_reg <= gain_next;
            muted_reg <= muted_next;
            state_reg <= state_next;
            tick_reg <= tickDone ? 16'h0000 : tick_reg + 16'h0001;
        end
    end

    assign appliedCode = gain_reg;
    assign recordMuted = muted_reg;
    assign rampBusy = (state_reg == ACR_RAMP);

    a_gain_one_step: assert property (@(posedge clk) disable iff (!rstn)
        (gain_reg != $past(gain_reg)) |-> ($past(tickDone)))
        else $error("gain moved without a step tick");
    a_mute_at_floor: assert property (@(posedge clk) disable iff (!rstn)
        $rose(muted_reg) |-> (gain_reg == GAIN_MIN))
        else $error("muted above floor gain");
endmodule : acr_gain_ramp
`default_nettype wire

/* File: core/acr_pkg.sv */
/*
 * Constants for the record and serial-audio setup registers: register indices,
 * field positions, reset values, encodings and soft-step timing.
 * Assumes a 100 MHz system clock.
 */
`default_nettype none
package acr_pkg;
    localparam int DATA_W = 16;
    localparam logic [6:0] ADDR_AUDIO_SETUP = 7'h00;
    localparam logic [6:0] ADDR_RECORD_GAIN = 7'h01;
    // Audio setup fields
    localparam int CORNER_LSB = 14;
    localparam int SOURCE_LSB = 12;
    localparam int PREAMP_LSB = 8;
    localparam int MCLK_LSB = 6;
    localparam int RATE_LSB = 2;
    localparam int FORMAT_LSB = 0;
    localparam logic [15:0] AUDIO_SETUP_MASK = 16'hf3ff;
    localparam logic [15:0] AUDIO_SETUP_RESET = 16'hc003;
    // Record gain fields
    localparam int MUTE_BIT = 15;
    localparam int GAIN_LSB = 8;
    localparam logic [15:0] RECORD_GAIN_MASK = 16'hff00;
    localparam logic [15:0] RECORD_GAIN_RESET = 16'hd700;
    localparam logic [6:0] GAIN_MAX = 7'h7f;
    localparam logic [6:0] GAIN_UNITY = 7'h57;
    localparam logic [6:0] GAIN_MIN = 7'h07;
    // Encodings
    localparam logic [1:0] CORNER_BYPASS = 2'h0;
    localparam logic [1:0] CORNER_TENTH = 2'h1;
    localparam logic [1:0] CORNER_78U = 2'h2;
    localparam logic [1:0] CORNER_19U = 2'h3;
    localparam logic [1:0] SRC_MIC = 2'h0;
    localparam logic [1:0] SRC_LEFT = 2'h1;
    localparam logic [1:0] SRC_RIGHT = 2'h2;
    localparam logic [1:0] SRC_MIX = 2'h3;
    localparam logic [3:0] RATE_MAX_CODE = 4'h8;
    localparam logic [9:0] RATIO_256 = 10'h100;
    localparam logic [9:0] RATIO_384 = 10'h180;
    localparam logic [9:0] RATIO_512 = 10'h200;
    localparam logic [1:0] FMT_RJ16 = 2'h0;
    localparam logic [1:0] FMT_RJ20 = 2'h1;
    localparam logic [1:0] FMT_LJ20 = 2'h2;
    localparam logic [1:0] FMT_STD20 = 2'h3;
    // Soft-step period
    localparam int CLK_MHZ = 100;
    localparam int STEP_US = 20;
    localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
    typedef enum logic [1:0] {ACR_MUTED, ACR_RAMP, ACR_ACTIVE} acr_ramp_t;
endpackage : acr_pkg
`default_nettype wire

/* File: core/acr_regs.sv */
/*
 * Record and serial-audio setup registers of the codec, written and read as
 * whole 16-bit words over the serial control bus, plus decoded controls.
 * Assumes the serial bus front end delivers a one-cycle wrStrobe after a
 * complete word has been shifted in, with wrAddr and wrData stable.
 */
`default_nettype none
module acr_regs #(
    parameter int STEP_CYC = acr_pkg::STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Word write from serial control bus
    input wire logic wrStrobe,
    input wire logic [6:0] wrAddr,
    input wire logic [acr_pkg::DATA_W-1:0] wrData,
    // Word read
    input wire logic [6:0] rdAddr,
    output logic [acr_pkg::DATA_W-1:0] rdData,
    // Decoded record path
    output logic [1:0] dcBlockCornerSel,
    output logic dcBlockBypass,
    output logic [1:0] recordSourceSel,
    output logic sourceIsMix,
    output logic [1:0] preampGainDb6,
    // Decoded clocking and format
    output logic [9:0] mclkRatio,
    output logic [3:0] sampleRateSel,
    output logic sampleRateValid,
    output logic [1:0] serialWordFormat,
    output logic wordIs20Bit,
    output logic playbackLeftJustified,
    output logic standardFraming,
    // Record gain
    output logic [6:0] recordGainApplied,
    output logic recordMute,
    output logic recordGainBusy
);
    import acr_pkg::*;

    logic [15:0] audioSetup_reg;
    logic [15:0] recordGain_reg;

    wire wrSetup = wrStrobe && (wrAddr == ADDR_AUDIO_SETUP);
    wire wrGain = wrStrobe && (wrAddr == ADDR_RECORD_GAIN);
    wire [1:0] cornerField = audioSetup_reg[CORNER_LSB +: 2];
    wire [1:0] preampField = audioSetup_reg[PREAMP_LSB +: 2];
    wire [1:0] mclkField = audioSetup_reg[MCLK_LSB +: 2];
    wire [1:0] fmtField = audioSetup_reg[FORMAT_LSB +: 2];
    wire muteBit = recordGain_reg[MUTE_BIT];
    wire [6:0] gainField = recordGain_reg[GAIN_LSB +: 7];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            audioSetup_reg <= AUDIO_SETUP_RESET;
            recordGain_reg <= RECORD_GAIN_RESET;
        end else begin
            if (wrSetup) begin
                audioSetup_reg <= wrData & AUDIO_SETUP_MASK;
            end
            if (wrGain) begin
                recordGain_reg <= wrData & RECORD_GAIN_MASK;
            end
        end
    end

    // Readback shows the stored words, reserved bits zero
    assign rdData = (rdAddr == ADDR_AUDIO_SETUP) ? audioSetup_reg :
                    (rdAddr == ADDR_RECORD_GAIN) ? recordGain_reg : 16'h0000;

    assign dcBlockCornerSel = cornerField;
    assign dcBlockBypass = (cornerField == CORNER_BYPASS);
    assign recordSourceSel = audioSetup_reg[SOURCE_LSB +: 2];
    assign sourceIsMix = (recordSourceSel == SRC_MIX);
    // Preamp gain in 6 dB units: 0, 0, 1, 2
    assign preampGainDb6 = preampField[1] ? {preampField[0], ~preampField[0]} : 2'h0;
    assign mclkRatio = (mclkField == 2'h1) ? RATIO_384 :
                       (mclkField == 2'h2) ? RATIO_512 : RATIO_256;
    assign sampleRateSel = audioSetup_reg[RATE_LSB +: 4];
    assign sampleRateValid = (sampleRateSel <= RATE_MAX_CODE);
    assign serialWordFormat = fmtField;
    assign wordIs20Bit = (fmtField != FMT_RJ16);
    assign playbackLeftJustified = (fmtField == FMT_LJ20);
    assign standardFraming = (fmtField == FMT_STD20);

    acr_gain_ramp #(
        .STEP_CYC(STEP_CYC)
    ) u_ramp (
        .clk(clk),
        .rstn(rstn),
        .muteReq(muteBit),
        .targetCode(gainField),
        .appliedCode(recordGainApplied),
        .recordMuted(recordMute),
        .rampBusy(recordGainBusy)
    );

    a_write_applies: assert property (@(posedge clk) disable iff (!rstn)
        wrSetup |=> (audioSetup_reg == $past(wrData & AUDIO_SETUP_MASK)))
        else $error("setup word not applied after write");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
        (audioSetup_reg[11:10] == 2'h0) && (recordGain_reg[7:0] == 8'h00))
        else $error("reserved bits not zero");
    a_mclk_decode: assert property (@(posedge clk) disable iff (!rstn)
        (mclkField == 2'h3) |-> (mclkRatio == RATIO_256))
        else $error("ratio code 11 not 256");
    a_bypass_decode: assert property (@(posedge clk) disable iff (!rstn)
        dcBlockBypass == (audioSetup_reg[15:14] == 2'h0))
        else $error("corner bypass decode wrong");
    a_preamp_decode: assert property (@(posedge clk) disable iff (!rstn)
        (preampField == 2'h3) |-> (preampGainDb6 == 2'h2))
        else $error("preamp 11 not 12 dB");
    a_gain_kept: assert property (@(posedge clk) disable iff (!rstn)
        (muteBit && !wrGain) |=> (gainField == $past(gainField)))
        else $error("stored gain changed while muted");
    a_unmute_starts: assert property (@(posedge clk) disable iff (!rstn)
        ($fell(muteBit) && recordMute && gainField >= GAIN_MIN) |=> !recordMute)
        else $error("unmute did not leave mute");
    a_format_decode: assert property (@(posedge clk) disable iff (!rstn)
        standardFraming |-> wordIs20Bit)
        else $error("standard framing not 20 bit");
endmodule : acr_regs
`default_nettype wire
